// file: verilog/ima_pkg.sv
// Shared constants and types for the indirect management access engine
package ima_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Slot and configuration map on the slot port
    localparam int unsigned SLOT_COUNT     = 8;
    localparam logic [3:0]  CFG_INDEX      = 4'h8;
    localparam logic [31:0] SLOT_RESET     = 32'h8000_0000;
    localparam logic        CFG_SPEED_RST  = 1'b0;

    // Slot and configuration field positions
    localparam int unsigned DATA_LSB       = 0;
    localparam int unsigned DEVAD_LSB      = 16;
    localparam int unsigned PRTAD_LSB      = 21;
    localparam int unsigned OP_LSB         = 26;
    localparam int unsigned FS_LSB         = 28;
    localparam int unsigned DONE_BIT       = 31;
    localparam int unsigned CFG_SPEED_BIT  = 0;

    // Opcodes and frame-start codes
    localparam logic [1:0]  OP_ADDR        = 2'h0;
    localparam logic [1:0]  OP_WR          = 2'h1;
    localparam logic [1:0]  OP_INC_RD      = 2'h2;
    localparam logic [1:0]  OP_RD          = 2'h3;
    localparam logic [1:0]  FS_C45         = 2'h0;
    localparam logic [1:0]  FS_C22         = 2'h1;
    localparam logic [1:0]  WIRE_ST_C45    = 2'h0;
    localparam logic [1:0]  WIRE_ST_C22    = 2'h1;
    localparam logic [1:0]  WIRE_OP_C22_RD = 2'h2;
    localparam logic [1:0]  WIRE_TA        = 2'h2;
    localparam logic [31:0] PREAMBLE       = 32'hffff_ffff;
    localparam logic [15:0] READ_FILL      = 16'hffff;

    // Frame bit positions, counted from the first preamble bit
    localparam logic [5:0]  LAST_BIT       = 6'h3f;
    localparam logic [5:0]  RELEASE_BIT    = 6'h2e;
    localparam logic [5:0]  DATA_BIT       = 6'h30;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int unsigned CLK_HZ         = 25_000_000;
    localparam int unsigned MDC_SLOW_HZ    = 2_500_000;
    localparam int unsigned MDC_FAST_HZ    = 4_166_000;
    localparam logic [2:0]  HALF_SLOW      = 3'(CLK_HZ / (2 * MDC_SLOW_HZ));
    localparam logic [2:0]  HALF_FAST      = 3'(CLK_HZ / (2 * MDC_FAST_HZ));

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite side
    localparam int unsigned AXI_AW         = 6;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef enum logic {
        DEV_SCAN,
        DEV_RUN
    } ima_dev_fsm_type;

    typedef enum logic [2:0] {
        HOST_IDLE,
        HOST_ACC_W,
        HOST_ACC_R,
        HOST_WAIT,
        HOST_BRESP,
        HOST_RRESP
    } ima_host_fsm_type;

endpackage

// file: verilog/ima_slot_if.sv
// Slot access port between the bus-side controller and the management engine
`timescale 1ns/1ps
interface ima_slot_if;
    logic        req;
    logic        we;
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [31:0] rdata;
    logic        ack;

    modport dev (
        input  req,
        input  we,
        input  addr,
        input  wdata,
        input  be,
        output rdata,
        output ack
    );

    modport host (
        output req,
        output we,
        output addr,
        output wdata,
        output be,
        input  rdata,
        input  ack
    );
endinterface

// file: verilog/ima_engine.sv
// Management engine: eight command slots and the management frame leader
//
// How it works
// - eight slots, each one management transaction
// - clock 2.5 MHz default, selectable 4.166
// - round-robin scan, launch slot with done zero
// - on completion set done, advance pointer
// - host loads port 0x1, device, start 0x0
// - address slot then write slot, in order
// - address slot then read, data returned
// - incrementing read slots, one register each
// - start 0x1 gives single-slot short frame
// - short read returns data, sets done
// - all eight slots may be armed at once
// - last slot done means earlier ones done
// - device addresses select manageable devices
`timescale 1ns/1ps
module ima_engine
    import ima_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic nrst_i,
    ima_slot_if.dev   bus,
    output logic      mdc_o,
    output logic      mdio_o,
    output logic      mdio_oe_n_o,
    input  wire logic mdio_i
);
    import ima_pkg::*;

    typedef struct packed {
        logic [SLOT_COUNT-1:0][31:0] slot;
        logic                        speed;
        logic [2:0]                  ptr;
        ima_dev_fsm_type             fsm;
        logic [2:0]                  cnt;
        logic                        mdc;
        logic                        mdo;
        logic                        oe_n;
        logic [63:0]                 shf;
        logic [5:0]                  bitn;
        logic                        rd_op;
        logic [15:0]                 rdat;
        logic [1:0]                  sync;
        logic                        ack;
        logic [31:0]                 rdata;
    } ima_dev_state_type;

    ima_dev_state_type state_reg;
    ima_dev_state_type state_next;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [31:0] cur;
        logic [2:0]  half;
        logic        c22;
        logic        rd;
        logic [1:0]  wop;
        cur        = state_reg.slot[state_reg.ptr];
        half       = HALF_SLOW;
        c22        = 1'b0;
        rd         = 1'b0;
        wop        = OP_ADDR;
        state_next = state_reg;
        state_next.ack  = 1'b0;
        // Two-stage synchroniser on the returning data pin
        state_next.sync = {state_reg.sync[0], mdio_i};

        if (bus.req) begin
            state_next.ack = 1'b1;
            if (bus.addr < CFG_INDEX) begin
                state_next.rdata = state_reg.slot[bus.addr[2:0]];
            end else if (bus.addr == CFG_INDEX) begin
                state_next.rdata = 32'h0;
                state_next.rdata[CFG_SPEED_BIT] = state_reg.speed;
            end else begin
                state_next.rdata = 32'h0;
            end
            if (bus.we) begin
                if (bus.addr < CFG_INDEX) begin
                    for (int b = 0; b < 4; b++) begin
                        if (bus.be[b]) begin
                            state_next.slot[bus.addr[2:0]][8*b +: 8] = bus.wdata[8*b +: 8];
                        end
                    end
                end else if (bus.addr == CFG_INDEX && bus.be[0]) begin
                    state_next.speed = bus.wdata[CFG_SPEED_BIT];
                end
            end
        end

        if (state_reg.speed) begin
            half = HALF_FAST;
        end

        unique case (state_reg.fsm)
            DEV_SCAN: begin
                if (!cur[DONE_BIT]) begin
                    c22 = (cur[FS_LSB +: 2] == FS_C22);
                    // incrementing read uses its own opcode
                    rd  = c22 ? (cur[OP_LSB +: 2] == OP_RD) : cur[OP_LSB + 1];
                    wop = (c22 && rd) ? WIRE_OP_C22_RD : cur[OP_LSB +: 2];
                    state_next.shf   = {PREAMBLE, (c22 ? WIRE_ST_C22 : WIRE_ST_C45), wop,
                                        cur[PRTAD_LSB +: 5], cur[DEVAD_LSB +: 5], WIRE_TA,
                                        (rd ? READ_FILL : cur[DATA_LSB +: 16])};
                    state_next.rd_op = rd;
                    state_next.mdo   = 1'b1;
                    state_next.oe_n  = 1'b0;
                    state_next.mdc   = 1'b0;
                    state_next.cnt   = 3'h0;
                    state_next.bitn  = 6'h0;
                    state_next.fsm   = DEV_RUN;
                end else begin
                    state_next.ptr = state_reg.ptr + 3'h1;
                end
            end
            DEV_RUN: begin
                if (state_reg.cnt == half - 3'h1 || state_reg.cnt >= half) begin
                    state_next.cnt = 3'h0;
                    state_next.mdc = ~state_reg.mdc;
                    if (!state_reg.mdc) begin
                        // sample read data on rising edge
                        if (state_reg.rd_op && state_reg.bitn >= DATA_BIT) begin
                            state_next.rdat = {state_reg.rdat[14:0], state_reg.sync[1]};
                        end
                    end else if (state_reg.bitn == LAST_BIT) begin
                        state_next.oe_n = 1'b1;
                        state_next.mdo  = 1'b1;
                        // read data into the read slot
                        if (state_reg.rd_op) begin
                            state_next.slot[state_reg.ptr][DATA_LSB +: 16] = state_reg.rdat;
                        end
                        // done set wins over a host clear
                        state_next.slot[state_reg.ptr][DONE_BIT] = 1'b1;
                        state_next.ptr = state_reg.ptr + 3'h1;
                        state_next.fsm = DEV_SCAN;
                    end else begin
                        state_next.bitn = state_reg.bitn + 6'h1;
                        state_next.shf  = {state_reg.shf[62:0], 1'b0};
                        state_next.mdo  = state_reg.shf[62];
                        // Release the pin from the turnaround on reads
                        state_next.oe_n = state_reg.rd_op && (state_reg.bitn >= RELEASE_BIT - 6'h1);
                    end
                end else begin
                    state_next.cnt = state_reg.cnt + 3'h1;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg       <= '0;
            state_reg.slot  <= {SLOT_COUNT{SLOT_RESET}};
            state_reg.speed <= CFG_SPEED_RST;
            state_reg.fsm   <= DEV_SCAN;
            state_reg.mdo   <= 1'b1;
            state_reg.oe_n  <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign mdc_o       = state_reg.mdc;
    assign mdio_o      = state_reg.mdo;
    assign mdio_oe_n_o = state_reg.oe_n;
    assign bus.ack     = state_reg.ack;
    assign bus.rdata   = state_reg.rdata;

endmodule

// file: verilog/ima_host.sv
// AXI4-Lite controller that reaches the engine slots over the slot port
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module ima_host
    import ima_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              nrst_i,
    ima_slot_if.host               bus,
    input  wire logic [AXI_AW-1:0] awaddr_i,
    input  wire logic              awvalid_i,
    output logic                   awready_o,
    input  wire logic [31:0]       wdata_i,
    input  wire logic [3:0]        wstrb_i,
    input  wire logic              wvalid_i,
    output logic                   wready_o,
    output logic [1:0]             bresp_o,
    output logic                   bvalid_o,
    input  wire logic              bready_i,
    input  wire logic [AXI_AW-1:0] araddr_i,
    input  wire logic              arvalid_i,
    output logic                   arready_o,
    output logic [31:0]            rdata_o,
    output logic [1:0]             rresp_o,
    output logic                   rvalid_o,
    input  wire logic              rready_i
);
    import ima_pkg::*;

    typedef struct packed {
        ima_host_fsm_type fsm;
        logic             awready;
        logic             wready;
        logic             arready;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [1:0]       rresp;
        logic [31:0]      rdata;
        logic             req;
        logic             we;
        logic [3:0]       addr;
        logic [31:0]      wdata;
        logic [3:0]       be;
    } ima_host_state_type;

    ima_host_state_type state_reg;
    ima_host_state_type state_next;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next = state_reg;
        state_next.req = 1'b0;
        unique case (state_reg.fsm)
            HOST_IDLE: begin
                // Writes first; one access at a time keeps slot order intact
                // Payload latched here: the master may drop it after the handshake
                if (awvalid_i && wvalid_i) begin
                    state_next.awready = 1'b1;
                    state_next.wready  = 1'b1;
                    state_next.we      = 1'b1;
                    state_next.addr    = awaddr_i[5:2];
                    state_next.wdata   = wdata_i;
                    state_next.be      = wstrb_i;
                    state_next.fsm     = HOST_ACC_W;
                end else if (arvalid_i) begin
                    state_next.arready = 1'b1;
                    state_next.we      = 1'b0;
                    state_next.addr    = araddr_i[5:2];
                    state_next.fsm     = HOST_ACC_R;
                end
            end
            HOST_ACC_W: begin
                state_next.awready = 1'b0;
                state_next.wready  = 1'b0;
                // slots may be armed back to back
                if (state_reg.addr <= CFG_INDEX) begin
                    state_next.req   = 1'b1;
                    state_next.fsm   = HOST_WAIT;
                end else begin
                    state_next.bvalid = 1'b1;
                    state_next.bresp  = RESP_SLVERR;
                    state_next.fsm    = HOST_BRESP;
                end
            end
            HOST_ACC_R: begin
                state_next.arready = 1'b0;
                if (state_reg.addr <= CFG_INDEX) begin
                    state_next.req  = 1'b1;
                    state_next.fsm  = HOST_WAIT;
                end else begin
                    state_next.rvalid = 1'b1;
                    state_next.rresp  = RESP_SLVERR;
                    state_next.rdata  = 32'h0;
                    state_next.fsm    = HOST_RRESP;
                end
            end
            HOST_WAIT: begin
                if (bus.ack) begin
                    if (state_reg.we) begin
                        state_next.bvalid = 1'b1;
                        state_next.bresp  = RESP_OKAY;
                        state_next.fsm    = HOST_BRESP;
                    end else begin
                        // done flag read straight from the slot
                        state_next.rvalid = 1'b1;
                        state_next.rresp  = RESP_OKAY;
                        state_next.rdata  = bus.rdata;
                        state_next.fsm    = HOST_RRESP;
                    end
                end
            end
            HOST_BRESP: begin
                if (bready_i) begin
                    state_next.bvalid = 1'b0;
                    state_next.fsm    = HOST_IDLE;
                end
            end
            HOST_RRESP: begin
                if (rready_i) begin
                    state_next.rvalid = 1'b0;
                    state_next.fsm    = HOST_IDLE;
                end
            end
            default: begin
                state_next.fsm = HOST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg     <= '0;
            state_reg.fsm <= HOST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign awready_o = state_reg.awready;
    assign wready_o  = state_reg.wready;
    assign arready_o = state_reg.arready;
    assign bvalid_o  = state_reg.bvalid;
    assign bresp_o   = state_reg.bresp;
    assign rvalid_o  = state_reg.rvalid;
    assign rresp_o   = state_reg.rresp;
    assign rdata_o   = state_reg.rdata;
    assign bus.req   = state_reg.req;
    assign bus.we    = state_reg.we;
    assign bus.addr  = state_reg.addr;
    assign bus.wdata = state_reg.wdata;
    assign bus.be    = state_reg.be;

endmodule

// file: verification/ima_monitor.sv
// Protocol checker for the slot port and the management pins
`timescale 1ns/1ps
module ima_monitor (
    input wire logic        clk_i,
    input wire logic        nrst_i,
    input wire logic        req,
    input wire logic        we,
    input wire logic [3:0]  addr,
    input wire logic [31:0] rdata,
    input wire logic        ack,
    input wire logic        mdc_o,
    input wire logic        mdio_o,
    input wire logic        mdio_oe_n_o
);

    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    ////////////////////////////////////////////////////////////////////////////
    a_ack_after_req: assert property (req |=> ack)
        else $error("slot ack missing one cycle after req");
    a_ack_has_cause: assert property (ack |-> $past(req))
        else $error("slot ack without a request");
    a_cfg_spare_zero: assert property (req && !we && addr == 4'h8 |=> rdata[31:1] == 31'h0)
        else $error("config word spare bits did not read zero");

    ////////////////////////////////////////////////////////////////////////////
    // Either rate keeps each phase at least three clocks
    a_mdc_high_min: assert property ($rose(mdc_o) |-> mdc_o [*3])
        else $error("management clock high phase too short");
    a_mdc_low_min: assert property ($fell(mdc_o) |-> !mdc_o [*3])
        else $error("management clock low phase too short");
    a_mdc_high_max: assert property ($rose(mdc_o) |-> ##[3:5] $fell(mdc_o))
        else $error("management clock high phase too long");

    ////////////////////////////////////////////////////////////////////////////
    a_data_on_fall: assert property ($changed(mdio_o) |-> $fell(mdc_o))
        else $error("data line moved outside a clock fall");
    a_release_on_fall: assert property ($rose(mdio_oe_n_o) |-> $fell(mdc_o))
        else $error("data line released outside a clock fall");
    a_launch_clean: assert property ($fell(mdio_oe_n_o) |-> !mdc_o && mdio_o)
        else $error("frame launched with clock high or preamble low");

endmodule

// file: verification/test_indirect_mdio_access_engine.sv
// Bench: bus-side controller and engine joined, far end answers over the data line
`timescale 1ns/1ps
module test_indirect_mdio_access_engine;
    import ima_pkg::*;

    logic        clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic [5:0]  awaddr = 6'h0, araddr = 6'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic [3:0]  wstrb = 4'hf;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic        mdc, mdio_out, mdio_oe_n, mdio_w;
    logic        phy_bit = 1'b1;
    logic [63:0] sr = 64'h0, fr;
    logic [63:0] frames[$], exp_q[$];
    logic [6:0]  cnt = 7'h0;
    logic [15:0] phy_addr = 16'h0, rd_val = 16'h0;
    int          errors = 0, cmp_count = 0;

    ima_slot_if slot();

    ima_host ima_host_i (.clk_i(clk_i), .nrst_i(nrst_i), .bus(slot), .awaddr_i(awaddr), .awvalid_i(awvalid),
        .awready_o(awready), .wdata_i(wdata), .wstrb_i(wstrb), .wvalid_i(wvalid), .wready_o(wready),
        .bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid),
        .arready_o(arready), .rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready));
    ima_engine ima_engine_i (.clk_i(clk_i), .nrst_i(nrst_i), .bus(slot), .mdc_o(mdc), .mdio_o(mdio_out),
        .mdio_oe_n_o(mdio_oe_n), .mdio_i(mdio_w));
    ima_monitor ima_monitor_i (.clk_i(clk_i), .nrst_i(nrst_i), .req(slot.req), .we(slot.we), .addr(slot.addr),
        .rdata(slot.rdata), .ack(slot.ack), .mdc_o(mdc), .mdio_o(mdio_out), .mdio_oe_n_o(mdio_oe_n));

    // Pull-up on the wire: released and undriven bits read 1
    assign mdio_w = mdio_oe_n ? phy_bit : mdio_out;

    always #20 clk_i = ~clk_i;

    ////////////////////////////////////////////////////////////////////////////
    // Far end: records frames, returns address ^ 16'h5a5a, advances on incrementing reads
    always @(posedge mdc) begin
        fr = {sr[62:0], mdio_w};
        sr <= fr;
        cnt <= (cnt == 7'h3f) ? 7'h0 : cnt + 7'h1;
        if (cnt == 7'h2e)
            rd_val <= 16'h5a5a ^ ((sr[13:12] == 2'h1) ? {11'h0, sr[4:0]} : phy_addr);
        if (cnt == 7'h3f) begin
            frames.push_back(fr);
            if (fr[31:28] == 4'h0)
                phy_addr <= fr[15:0];
            if (fr[31:28] == 4'h2)
                phy_addr <= phy_addr + 16'h1;
        end
    end

    always @(negedge mdc) phy_bit <= (cnt == 7'h2f) ? 1'b0 : (cnt > 7'h2f) ? rd_val[7'h3f - cnt] : 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] slot_word(input logic [1:0] fs, op, input logic [4:0] dev, input logic [15:0] d);
        return {2'h0, fs, op, 5'h01, dev, d};
    endfunction

    function automatic logic [63:0] frame(input logic [1:0] st, op, input logic [4:0] dev, input logic [15:0] d);
        return {32'hffff_ffff, st, op, 5'h01, dev, 2'h2, d};
    endfunction

    task automatic chk(input logic [63:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge clk_i); while (!(awready === 1'b1 && wready === 1'b1));
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge clk_i); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp, er);
    endtask

    task automatic axi_rd(input logic [5:0] a, input logic [1:0] er);
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk_i); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk_i); while (rvalid !== 1'b1);
        rready <= 1'b0;
        v = rdata;
        chk(rresp, er);
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
        axi_rd(a, RESP_OKAY);
        chk(v, e);
    endtask

    // Polls done only; the watchdog bounds a slot that never finishes
    task automatic wait_done(input logic [5:0] a);
        do axi_rd(a, RESP_OKAY); while (v[31] !== 1'b1);
    endtask

    task automatic chk_frames;
        chk(frames.size(), exp_q.size());
        foreach (exp_q[i])
            if (i < frames.size())
                chk(frames[i], exp_q[i]);
        frames.delete();
        exp_q.delete();
    endtask

    task automatic mdc_high(input int half);
        time t;
        @(posedge mdc);
        t = $time;
        @(negedge mdc);
        chk(($time - t) / 40, half);
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk_i);
        errors++;
        end_of_test;
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk_i);
        nrst_i <= 1'b1;
        for (int i = 0; i < 9; i++)
            rd_chk(6'(4 * i), (i < 8) ? SLOT_RESET : 32'h0);
        axi_rd(6'h24, RESP_SLVERR);
        chk(v, 32'h0);
        axi_wr(6'h3c, 32'h0, RESP_SLVERR);
        $display("test reset_map done");

        axi_wr(6'h00, slot_word(FS_C45, OP_ADDR, 5'h01, 16'h0012), RESP_OKAY);
        axi_wr(6'h04, slot_word(FS_C45, OP_WR, 5'h01, 16'hbeef), RESP_OKAY);
        mdc_high(5);
        wait_done(6'h04);
        rd_chk(6'h00, SLOT_RESET | slot_word(FS_C45, OP_ADDR, 5'h01, 16'h0012));
        exp_q = '{frame(2'h0, 2'h0, 5'h01, 16'h0012), frame(2'h0, 2'h1, 5'h01, 16'hbeef)};
        chk_frames;
        $display("test c45_write done");

        axi_wr(6'h08, slot_word(FS_C45, OP_ADDR, 5'h03, 16'h0034), RESP_OKAY);
        axi_wr(6'h0c, slot_word(FS_C45, OP_RD, 5'h03, 16'h0000), RESP_OKAY);
        wait_done(6'h0c);
        rd_chk(6'h0c, SLOT_RESET | slot_word(FS_C45, OP_RD, 5'h03, 16'h0034 ^ 16'h5a5a));
        exp_q = '{frame(2'h0, 2'h0, 5'h03, 16'h0034), frame(2'h0, 2'h3, 5'h03, 16'h0034 ^ 16'h5a5a)};
        chk_frames;
        $display("test c45_read done");

        axi_wr(6'h00, slot_word(FS_C45, OP_ADDR, 5'h07, 16'h0100), RESP_OKAY);
        exp_q.push_back(frame(2'h0, 2'h0, 5'h07, 16'h0100));
        for (int k = 1; k < 8; k++) begin
            axi_wr(6'(4 * k), slot_word(FS_C45, OP_INC_RD, 5'h07, 16'h0), RESP_OKAY);
            exp_q.push_back(frame(2'h0, 2'h2, 5'h07, (16'h0100 + 16'(k - 1)) ^ 16'h5a5a));
        end
        wait_done(6'h1c);
        for (int k = 1; k < 8; k++)
            rd_chk(6'(4 * k), SLOT_RESET | slot_word(2'h0, 2'h2, 5'h07, (16'h0100 + 16'(k - 1)) ^ 16'h5a5a));
        chk_frames;
        $display("test inc_burst done");

        axi_wr(6'h20, 32'h1, RESP_OKAY);
        rd_chk(6'h20, 32'h1);
        axi_wr(6'h00, slot_word(FS_C22, OP_WR, 5'h09, 16'h1357), RESP_OKAY);
        axi_wr(6'h04, slot_word(FS_C22, OP_RD, 5'h09, 16'h0), RESP_OKAY);
        mdc_high(3);
        wait_done(6'h04);
        rd_chk(6'h04, SLOT_RESET | slot_word(FS_C22, OP_RD, 5'h09, 16'h0009 ^ 16'h5a5a));
        exp_q = '{frame(2'h1, 2'h1, 5'h09, 16'h1357), frame(2'h1, 2'h2, 5'h09, 16'h0009 ^ 16'h5a5a)};
        chk_frames;
        $display("test c22_fast done");
        end_of_test;
    end

endmodule
